// ==== rtl/dwu_pkg.sv ====
// Purpose: Shared constants and types of the dual watchdog unit.
// Assumes: Main clock at 125 MHz; slow oscillator near 32 kHz.
// Notes: Counter widths are fixed by the carrier structs below.

package dwu_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SLOW_OSC_FREQ_HZ = 32000;
    localparam int RST_HOLD_NS = 1000;
    // Least time, so round up
    localparam int RST_HOLD_CYC =
        (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_HOLD_W = 8;
    localparam int WW_DIV_DEF = 4096;

    // ------------------------------------------------------------
    // Widths and values
    // ------------------------------------------------------------
    localparam int IW_CNT_W = 12;
    localparam int IW_PRE_W = 8;
    localparam int WW_CNT_W = 7;
    localparam logic [11:0] IW_CNT_RST = 12'hFFF;
    localparam logic [7:0] IW_PRE_RST = 8'h00;
    localparam logic [6:0] WW_CNT_RST = 7'h7F;
    localparam logic [6:0] WW_EARLY_VAL = 7'h40;
    localparam logic [1:0] STRAP_DONE = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic resetMode;
        logic freezeDbg;
        logic [7:0] prescLimit;
        logic [11:0] reloadVal;
    } dwu_iw_cfg_t;

    typedef struct packed {
        logic freeRun;
        logic freezeDbg;
        logic earlyIrqEn;
        logic [6:0] window;
    } dwu_ww_cfg_t;

    typedef struct packed {
        logic iw;
        logic ww;
    } dwu_cause_t;

    typedef enum logic [1:0] {
        IW_OFF = 2'b01,
        IW_RUN = 2'b10
    } dwu_iw_state_t;

endpackage : dwu_pkg

// ==== rtl/dwu_dual_watchdog_unit.sv ====
// Purpose: Independent watchdog on the slow oscillator plus window
//          watchdog on the main clock, with a shared reset request.
// Assumes: Slow oscillator is far slower than clk_sys.
// Notes: All control bits are plain ports; no register bus.

`timescale 1ns/1ns
`default_nettype none

// How it works
// - Independent watchdog: 12-bit down-counter stepped by 8-bit prescaler.
// - It steps on the slow oscillator and ignores the low-power input.
// - Expiry always reloads; it resets in reset mode, else pulses a timeout.
// - A strap read after reset release picks hardware or software start.
// - Independent counter holds during debug halt with its freeze bit set.
// - Window watchdog: 7-bit down-counter on clk_sys that can run freely.
// - Started and not free-running, window watchdog resets on a step past 0x40 or on an early reload.
// - It raises an early-warning interrupt when the counter reaches 0x40.
// - The window counter holds while debug halt and its freeze bit are high.
module dwu_dual_watchdog_unit
    import dwu_pkg::*;
#(
    parameter int WW_DIV = WW_DIV_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Pins and system state
    input wire logic lowSpeedOscClk,
    input wire logic optHwStart,
    input wire logic debugHalt,
    input wire logic lowPowerMode,
    // Independent watchdog control
    input wire dwu_iw_cfg_t iwCfg,
    input wire logic iwStart,
    input wire logic iwReload,
    // Window watchdog control
    input wire dwu_ww_cfg_t wwCfg,
    input wire logic wwStart,
    input wire logic wwWrite,
    input wire logic [6:0] wwWriteVal,
    input wire logic wwIrqClear,
    input wire logic causeClear,
    // Status and results
    output logic [11:0] iwCount,
    output logic iwRunning,
    output logic iwTimeout,
    output logic [6:0] wwCount,
    output logic wwEarlyIrq,
    output logic sysReset,
    output var dwu_cause_t resetCause
);

    localparam int DIV_W = $clog2(WW_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(WW_DIV - 1);

    // ------------------------------------------------------------
    // Synchronisers and strap capture
    // ------------------------------------------------------------
    logic oscMeta_reg, oscSync_reg, oscLast_reg;
    logic strapMeta_reg, strapSync_reg;
    logic [1:0] strapCnt_reg, strapCnt_next;
    logic oscRise;

    always_comb begin
        strapCnt_next = strapCnt_reg;
        if (strapCnt_reg != STRAP_DONE + 2'h1) begin
            strapCnt_next = strapCnt_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            oscMeta_reg <= 1'b0;
            oscSync_reg <= 1'b0;
            oscLast_reg <= 1'b0;
            strapMeta_reg <= 1'b0;
            strapSync_reg <= 1'b0;
            strapCnt_reg <= 2'h0;
        end else begin
            oscMeta_reg <= lowSpeedOscClk;
            oscSync_reg <= oscMeta_reg;
            oscLast_reg <= oscSync_reg;
            strapMeta_reg <= optHwStart;
            strapSync_reg <= strapMeta_reg;
            strapCnt_reg <= strapCnt_next;
        end
    end

    assign oscRise = oscSync_reg & ~oscLast_reg;

    // ------------------------------------------------------------
    // Independent watchdog
    // ------------------------------------------------------------
    dwu_iw_state_t iwState_reg, iwState_next;
    logic [11:0] iwCnt_reg, iwCnt_next;
    logic [7:0] iwPre_reg, iwPre_next;
    logic iwTimeout_reg, iwTimeout_next;
    logic iwFire;
    logic iwGo;
    logic iwFreeze;

    // Strap read once, two edges after reset release, when the synchroniser has just settled
    assign iwGo = iwStart
        | (strapCnt_reg == STRAP_DONE && strapSync_reg);
    assign iwFreeze = iwCfg.freezeDbg & debugHalt;

    always_comb begin
        iwState_next = iwState_reg;
        iwCnt_next = iwCnt_reg;
        iwPre_next = iwPre_reg;
        iwTimeout_next = 1'b0;
        iwFire = 1'b0;
        case (iwState_reg)
            IW_OFF: begin
                if (iwGo) begin
                    iwState_next = IW_RUN;
                    iwCnt_next = iwCfg.reloadVal;
                    iwPre_next = IW_PRE_RST;
                end
            end
            IW_RUN: begin
                // Once started only a power-on reset stops it
                if (iwReload) begin
                    iwCnt_next = iwCfg.reloadVal;
                    iwPre_next = IW_PRE_RST;
                end else if (oscRise && !iwFreeze) begin
                    if (iwPre_reg == iwCfg.prescLimit) begin
                        iwPre_next = IW_PRE_RST;
                        if (iwCnt_reg == 12'h000) begin
                            iwCnt_next = iwCfg.reloadVal;
                            iwTimeout_next = ~iwCfg.resetMode;
                            iwFire = iwCfg.resetMode;
                        end else begin
                            iwCnt_next = iwCnt_reg - 12'h001;
                        end
                    end else begin
                        iwPre_next = iwPre_reg + 8'h01;
                    end
                end
            end
            default: begin
                iwState_next = IW_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            iwState_reg <= IW_OFF;
            iwCnt_reg <= IW_CNT_RST;
            iwPre_reg <= IW_PRE_RST;
            iwTimeout_reg <= 1'b0;
        end else begin
            iwState_reg <= iwState_next;
            iwCnt_reg <= iwCnt_next;
            iwPre_reg <= iwPre_next;
            iwTimeout_reg <= iwTimeout_next;
        end
    end

    // ------------------------------------------------------------
    // Window watchdog
    // ------------------------------------------------------------
    logic wwEn_reg, wwEn_next;
    logic [6:0] wwCnt_reg, wwCnt_next;
    logic [DIV_W-1:0] wwDiv_reg, wwDiv_next;
    logic wwEarly_reg, wwEarly_next;
    logic wwIrq_reg, wwIrq_next;
    logic wwRun, wwTick, wwGuard, wwFire;

    // Main clock is gated in low power, so the window counter waits
    assign wwRun = (wwEn_reg | wwCfg.freeRun) & ~lowPowerMode
        & ~(wwCfg.freezeDbg & debugHalt);
    assign wwTick = wwRun && wwDiv_reg == DIV_LAST;
    assign wwGuard = wwEn_reg & ~wwCfg.freeRun;
    assign wwFire = wwGuard & ~wwWrite & wwTick
            & (wwCnt_reg == WW_EARLY_VAL)
        | wwGuard & wwWrite & (wwCnt_reg > wwCfg.window);

    always_comb begin
        wwEn_next = wwEn_reg;
        wwCnt_next = wwCnt_reg;
        wwDiv_next = wwDiv_reg;
        wwEarly_next = wwEarly_reg;
        if (wwStart) begin
            wwEn_next = 1'b1;
        end
        if (wwWrite) begin
            wwCnt_next = wwWriteVal;
            wwDiv_next = '0;
        end else if (wwRun) begin
            wwDiv_next = wwTick ? '0 : wwDiv_reg + DIV_W'(1);
            if (wwTick) begin
                wwCnt_next = wwCnt_reg - 7'h01;
            end
        end
        // Set wins over a clear in the same cycle
        if (wwIrqClear) begin
            wwEarly_next = 1'b0;
        end
        if (wwTick && !wwWrite && wwCnt_reg == WW_EARLY_VAL + 7'h01) begin
            wwEarly_next = 1'b1;
        end
        if (wwFire || iwFire) begin
            wwEn_next = 1'b0;
        end
        wwIrq_next = wwEarly_next & wwCfg.earlyIrqEn;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wwEn_reg <= 1'b0;
            wwCnt_reg <= WW_CNT_RST;
            wwDiv_reg <= '0;
            wwEarly_reg <= 1'b0;
            wwIrq_reg <= 1'b0;
        end else begin
            wwEn_reg <= wwEn_next;
            wwCnt_reg <= wwCnt_next;
            wwDiv_reg <= wwDiv_next;
            wwEarly_reg <= wwEarly_next;
            wwIrq_reg <= wwIrq_next;
        end
    end

    // ------------------------------------------------------------
    // Reset request and cause
    // ------------------------------------------------------------
    logic [RST_HOLD_W-1:0] rstHold_reg, rstHold_next;
    logic sysReset_reg, sysReset_next;
    dwu_cause_t cause_reg, cause_next;

    always_comb begin
        rstHold_next = rstHold_reg;
        cause_next = cause_reg;
        if (iwFire || wwFire) begin
            rstHold_next = RST_HOLD_W'(RST_HOLD_CYC);
        end else if (rstHold_reg != '0) begin
            rstHold_next = rstHold_reg - RST_HOLD_W'(1);
        end
        if (causeClear) begin
            cause_next = '0;
        end
        // A new cause beats a clear arriving together
        if (iwFire) begin
            cause_next.iw = 1'b1;
        end
        if (wwFire) begin
            cause_next.ww = 1'b1;
        end
        sysReset_next = rstHold_next != '0;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstHold_reg <= '0;
            sysReset_reg <= 1'b0;
            cause_reg <= '0;
        end else begin
            rstHold_reg <= rstHold_next;
            sysReset_reg <= sysReset_next;
            cause_reg <= cause_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign iwCount = iwCnt_reg;
    assign iwRunning = iwState_reg[1];
    assign iwTimeout = iwTimeout_reg;
    assign wwCount = wwCnt_reg;
    assign wwEarlyIrq = wwIrq_reg;
    assign sysReset = sysReset_reg;
    assign resetCause = cause_reg;

endmodule : dwu_dual_watchdog_unit

`default_nettype wire

// ==== verification/dwu_properties.sv ====
// Purpose: Port timing checks of the dual watchdog unit.
// Assumes: Bound onto the unit from the bench top file.
// Notes: Hold counter saturates, so restarted holds only read longer.
`timescale 1ns/1ns
`default_nettype none
module dwu_properties
    import dwu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Controls
    input wire logic debugHalt,
    input wire dwu_iw_cfg_t iwCfg,
    input wire logic iwStart,
    input wire logic iwReload,
    input wire dwu_ww_cfg_t wwCfg,
    input wire logic wwWrite,
    // Results
    input wire logic [11:0] iwCount,
    input wire logic iwRunning,
    input wire logic iwTimeout,
    input wire logic [6:0] wwCount,
    input wire logic wwEarlyIrq,
    input wire logic sysReset
);
    // ------------------------------------------------------------
    // Length of the current reset pulse
    // ------------------------------------------------------------
    logic [7:0] holdCnt_reg;
    logic [7:0] holdCnt_next;
    always_comb begin
        holdCnt_next = sysReset
            ? holdCnt_reg + {7'h00, !(&holdCnt_reg)} : 8'h00;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            holdCnt_reg <= 8'h00;
        end else begin
            holdCnt_reg <= holdCnt_next;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence s_iwFrozen;
        iwRunning && debugHalt && iwCfg.freezeDbg && !iwReload;
    endsequence
    sequence s_wwFrozen;
        debugHalt && wwCfg.freezeDbg && !wwWrite;
    endsequence
    property p_iwStart;
        iwStart && !iwRunning
            |=> iwRunning && iwCount == $past(iwCfg.reloadVal);
    endproperty
    property p_iwReload;
        iwReload && iwRunning |=> iwCount == $past(iwCfg.reloadVal);
    endproperty
    property p_iwTimeout;
        iwTimeout |-> !$past(iwCfg.resetMode) ##1 !iwTimeout;
    endproperty
    property p_iwFreeze;
        s_iwFrozen |=> $stable(iwCount);
    endproperty
    property p_wwStep;
        $changed(wwCount) && !$past(wwWrite)
            |-> wwCount == $past(wwCount) - 7'h01;
    endproperty
    property p_wwFreeze;
        s_wwFrozen |=> $stable(wwCount);
    endproperty
    property p_wwEarly;
        // A late enable may raise the line on an old flag; not a step
        $rose(wwEarlyIrq) && $past(wwCfg.earlyIrqEn, 2)
            |-> wwCount == WW_EARLY_VAL && $past(wwCfg.earlyIrqEn);
    endproperty
    property p_hold;
        $fell(sysReset) |-> holdCnt_reg >= RST_HOLD_CYC;
    endproperty
    a_iwStart: assert property (p_iwStart) else $error("bad start");
    a_iwReload: assert property (p_iwReload) else $error("bad kick");
    a_iwTimeout: assert property (p_iwTimeout) else $error("bad pulse");
    a_iwFreeze: assert property (p_iwFreeze) else $error("iw moved");
    a_wwStep: assert property (p_wwStep) else $error("bad step");
    a_wwFreeze: assert property (p_wwFreeze) else $error("ww moved");
    a_wwEarly: assert property (p_wwEarly) else $error("bad early");
    a_hold: assert property (p_hold) else $error("hold short");
endmodule : dwu_properties
`default_nettype wire

// ==== verification/dwu_dual_watchdog_unit_tb.sv ====
// Purpose: Directed bench for the dual watchdog unit.
// Assumes: Window divider 8; prescaler limit 1, so two rising osc edges a step.
// Notes: Slow oscillator toggles every 5 clk_sys cycles, only when asked.
`timescale 1ns/1ns
`default_nettype none
module dwu_dual_watchdog_unit_tb
    import dwu_pkg::*;
();
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic lowSpeedOscClk = 1'b0, optHwStart = 1'b0, debugHalt = 1'b0;
    logic lowPowerMode = 1'b0;
    logic [6:0] wwWriteVal = 7'h00;
    // Pulse bits: causeClear, wwIrqClear, wwWrite, wwStart, iwReload, iwStart
    logic [5:0] pls = 6'h00;
    wire logic iwStart, iwReload, wwStart, wwWrite, wwIrqClear, causeClear;
    dwu_iw_cfg_t iwCfg = '{1'b0, 1'b1, 8'h01, 12'h003};
    dwu_ww_cfg_t wwCfg = '{1'b0, 1'b1, 1'b1, 7'h7F};
    logic [11:0] iwCount;
    logic [6:0] wwCount;
    logic iwRunning, iwTimeout, wwEarlyIrq, sysReset;
    dwu_cause_t resetCause;
    int num_errors = 0, compares = 0, toSeen = 0;

    assign {causeClear, wwIrqClear, wwWrite, wwStart, iwReload, iwStart} = pls;
    dwu_dual_watchdog_unit #(.WW_DIV(8)) dut (.clk_sys, .reset_n,
        .lowSpeedOscClk, .optHwStart, .debugHalt, .lowPowerMode, .iwCfg,
        .iwStart, .iwReload, .wwCfg, .wwStart, .wwWrite, .wwWriteVal,
        .wwIrqClear, .causeClear, .iwCount, .iwRunning, .iwTimeout,
        .wwCount, .wwEarlyIrq, .sysReset, .resetCause);

    initial forever #4 clk_sys = ~clk_sys;

    // Timeout pulses counted mid-cycle, where they stand settled
    always @(negedge clk_sys) toSeen += (iwTimeout === 1'b1);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic pulse(logic [5:0] p, logic [6:0] v = 7'h00);
        @(posedge clk_sys) pls <= p;
        wwWriteVal <= v;
        @(posedge clk_sys) pls <= 6'h00;
        #1;
    endtask : pulse
    // Whole oscillator periods
    task automatic osc(int n);
        repeat (2 * n) begin
            repeat (5) @(posedge clk_sys);
            lowSpeedOscClk <= ~lowSpeedOscClk;
        end
        #1;
    endtask : osc
    task automatic waitUntil(logic sel, logic val, int lim);
        int k = 0;
        while ((sel ? sysReset : wwEarlyIrq) !== val) begin
            @(posedge clk_sys);
            k++;
            if (k > lim) begin
                num_errors++;
                give_verdict();
            end
        end
        #1;
    endtask : waitUntil

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        cyc(6);
        check(iwCount, 16'h0FFF);
        check(wwCount, 16'h007F);
        check({iwRunning, sysReset, resetCause}, 16'h0000);
        pulse(6'h01);
        check({iwRunning, iwCount}, 16'h1003);
        osc(2);
        check(iwCount, 16'h0002);
        @(posedge clk_sys) debugHalt <= 1'b1;
        osc(2);
        check(iwCount, 16'h0002);
        @(posedge clk_sys) debugHalt <= 1'b0;
        lowPowerMode <= 1'b1;
        osc(6);
        check({sysReset, toSeen[2:0], iwCount}, 16'h1003);
        osc(2);
        pulse(6'h02);
        check(iwCount, 16'h0003);
        @(posedge clk_sys) iwCfg.resetMode <= 1'b1;
        osc(8);
        check({sysReset, toSeen[2:0], resetCause}, 16'h0026);
        waitUntil(1'b1, 1'b0, 300);
        pulse(6'h20);
        check(resetCause, 16'h0000);
        @(posedge clk_sys) lowPowerMode <= 1'b0;
        pulse(6'h0C, 7'h45);
        waitUntil(1'b0, 1'b1, 100);
        check(wwCount, 16'h0040);
        pulse(6'h10);
        cyc(1);
        check(wwEarlyIrq, 16'h0000);
        waitUntil(1'b1, 1'b1, 40);
        check({wwCount, resetCause}, 16'h00FD);
        waitUntil(1'b1, 1'b0, 300);
        pulse(6'h20);
        @(posedge clk_sys) wwCfg.window <= 7'h50;
        pulse(6'h0C, 7'h60);
        cyc(2);
        check(sysReset, 16'h0000);
        pulse(6'h08, 7'h60);
        cyc(2);
        check({sysReset, resetCause}, 16'h0005);
        waitUntil(1'b1, 1'b0, 300);
        @(posedge clk_sys) wwCfg.freeRun <= 1'b1;
        pulse(6'h08, 7'h00);
        cyc(10);
        check({sysReset, wwCount}, 16'h007F);
        @(posedge clk_sys) debugHalt <= 1'b1;
        cyc(20);
        check(wwCount, 16'h007F);
        @(posedge clk_sys) reset_n <= 1'b0;
        optHwStart <= 1'b1;
        cyc(12);
        @(posedge clk_sys) reset_n <= 1'b1;
        cyc(6);
        check(iwRunning, 16'h0001);
        give_verdict();
    end
endmodule : dwu_dual_watchdog_unit_tb

bind dwu_dual_watchdog_unit dwu_properties u_props (.clk_sys, .reset_n,
    .debugHalt, .iwCfg, .iwStart, .iwReload, .wwCfg, .wwWrite, .iwCount,
    .iwRunning, .iwTimeout, .wwCount, .wwEarlyIrq, .sysReset);
`default_nettype wire
